// file: common/clkgen_regs_pkg.sv
// Package: register map, field layout, reset values and carriers of the clock generator register bank
package clkgen_regs_pkg;

    // Byte offsets on the SMBus byte-register space
    localparam logic [7:0] OFS_DELTA_HIGH = 8'h05;
    localparam logic [7:0] OFS_SPREAD = 8'h06;
    localparam logic [7:0] OFS_PIN_READBACK = 8'h07;
    localparam logic [7:0] OFS_VENDOR_REV = 8'h08;
    localparam logic [7:0] OFS_DEVICE = 8'h09;
    localparam logic [7:0] OFS_BYTE_COUNT = 8'h0a;
    localparam logic [7:0] OFS_MASK_FAST = 8'h0b;
    localparam logic [7:0] OFS_MASK_SELECTABLE = 8'h0c;
    localparam logic [7:0] OFS_MASK_SLOW = 8'h0d;

    // Spread-spectrum register fields
    localparam int SPREAD_PIN_RB_LSB = 4;
    localparam int SPREAD_REF_BIT = 3;
    localparam int SPREAD_PIN_DISABLE_BIT = 2;
    localparam int SPREAD_SEL_LSB = 0;

    // Spread encodings
    localparam logic [1:0] SPREAD_OFF = 2'h0;
    localparam logic [1:0] SPREAD_DOWN_0P3 = 2'h1;
    localparam logic [1:0] SPREAD_RESERVED = 2'h2;
    localparam logic [1:0] SPREAD_DOWN_0P5 = 2'h3;

    // Device type encodings
    localparam logic [1:0] TYPE_CLOCK_GENERATOR = 2'h0;
    localparam logic [1:0] TYPE_ZERO_DELAY_BUFFER = 2'h1;
    localparam logic [1:0] TYPE_RESERVED = 2'h2;
    localparam logic [1:0] TYPE_NONZERO_DELAY_BUFFER = 2'h3;

    // Identity values: arbitrary neutral values
    localparam logic [3:0] DIE_REVISION = 4'h1;
    localparam logic [3:0] VENDOR_CODE = 4'h5;
    localparam logic [5:0] DEVICE_IDENTIFIER = 6'h2a;

    // Reset values
    localparam logic RST_SPREAD_REF = 1'b0;
    localparam logic RST_SPREAD_PIN_DISABLE = 1'b0;
    localparam logic [5:0] RST_READ_COUNT = 6'h08;
    localparam logic [7:0] RST_MASK = 8'h00;
    localparam logic [3:0] RST_MASK_SLOW = 4'h0;

    // Output counts
    localparam int NUM_FAST = 7;
    localparam int NUM_SELECTABLE = 9;
    localparam int NUM_SLOW = 3;

    // SMBus byte access carried to the register bank
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_access_t;

    // Per-output enable-qualifying controls from elsewhere in the chip
    typedef struct packed {
        logic [NUM_FAST-1:0] fast;
        logic [NUM_SELECTABLE-1:0] selectable;
        logic [NUM_SLOW-1:0] slow;
        logic platform_time_output;
    } output_vec_t;

endpackage

// file: hdl/clock_gen_ctrl_status_regs.sv
// Configuration and status register bank of the clock generator
//
// Functional notes
// - Upper byte of platform-time frequency delta
// - Spread applies to fast, selectable-at-100MHz outputs
// - Bits 5:4 show spread strap live
// - Bit 3 picks spread reference, crystal default
// - Filter reference gives no output alignment
// - Bit 2 hands spread control to register
// - Bits 1:0 select spread, strap-loaded
// - Pin readback: inverted active-low enable pins
// - Identification byte: revision and vendor
// - Device type in bits 7:6
// - Six-bit device identifier in bits 5:0
// - Read byte count, resets to eight
// - Mask bit stops sideband disabling output
// - First mask: selectable 8, fast 6..0
// - Second mask: selectable 7..0
// - Third mask: platform-time, slow 2..0
// - Frequency select: pin or register bit
// - Fast enable needs SMBus bit, pin, sideband; other outputs need SMBus bit, sideband
`timescale 1ns/100ps
`default_nettype none

module clock_gen_ctrl_status_regs (
    input wire logic ref_clk,
    input wire logic rst,
    input wire clkgen_regs_pkg::reg_access_t bus,
    output logic [7:0] rdata,
    output logic addr_hit,
    input wire logic [15:0] platform_time_delta,
    input wire logic [1:0] spread_strap_pin,
    input wire logic [6:0] enable_pin_n,
    input wire logic selectable_select_pin,
    input wire logic selectable_freq_select,
    input wire logic selectable_freq_control,
    input wire clkgen_regs_pkg::output_vec_t smbus_enable,
    input wire clkgen_regs_pkg::output_vec_t sideband_latched,
    output clkgen_regs_pkg::output_vec_t output_enable,
    output logic selectable_is_slow,
    output logic [1:0] spread_mode,
    output logic spread_ref_filter,
    output logic [clkgen_regs_pkg::NUM_SELECTABLE-1:0] selectable_spread,
    output logic outputs_aligned,
    output logic [5:0] read_count_field
);

    ////////////////////////////////////////////////////////////////////////
    // Writable state

    logic spread_ref;
    logic spread_pin_disable;
    logic [1:0] spread_select_field;
    logic strap_pending;
    logic [7:0] mask_fast;
    logic [7:0] mask_selectable;
    logic [3:0] mask_slow;

    function automatic logic hit(input clkgen_regs_pkg::reg_access_t a,
                                 input logic [7:0] ofs);
        hit = a.wr && (a.addr == ofs);
    endfunction

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            spread_ref <= clkgen_regs_pkg::RST_SPREAD_REF;
            spread_pin_disable <= clkgen_regs_pkg::RST_SPREAD_PIN_DISABLE;
        end else if (hit(bus, clkgen_regs_pkg::OFS_SPREAD)) begin
            spread_ref <= bus.wdata[clkgen_regs_pkg::SPREAD_REF_BIT];
            spread_pin_disable <= bus.wdata[clkgen_regs_pkg::SPREAD_PIN_DISABLE_BIT];
        end
    end

    // Strap cannot be sampled under reset, so it is caught on the first edge after release
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            strap_pending <= 1'b1;
            spread_select_field <= clkgen_regs_pkg::SPREAD_OFF;
        end else if (strap_pending) begin
            strap_pending <= 1'b0;
            spread_select_field <= spread_strap_pin;
        end else if (hit(bus, clkgen_regs_pkg::OFS_SPREAD)) begin
            spread_select_field <= bus.wdata[clkgen_regs_pkg::SPREAD_SEL_LSB +: 2];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            read_count_field <= clkgen_regs_pkg::RST_READ_COUNT;
        end else if (hit(bus, clkgen_regs_pkg::OFS_BYTE_COUNT)) begin
            read_count_field <= bus.wdata[5:0];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            mask_fast <= clkgen_regs_pkg::RST_MASK;
            mask_selectable <= clkgen_regs_pkg::RST_MASK;
            mask_slow <= clkgen_regs_pkg::RST_MASK_SLOW;
        end else begin
            if (hit(bus, clkgen_regs_pkg::OFS_MASK_FAST)) begin
                mask_fast <= bus.wdata;
            end
            if (hit(bus, clkgen_regs_pkg::OFS_MASK_SELECTABLE)) begin
                mask_selectable <= bus.wdata;
            end
            if (hit(bus, clkgen_regs_pkg::OFS_MASK_SLOW)) begin
                mask_slow <= bus.wdata[3:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Clock steering

    always_comb begin
        selectable_is_slow = selectable_freq_control ? selectable_freq_select
                                                     : selectable_select_pin;
        spread_mode = spread_pin_disable ? spread_select_field : spread_strap_pin;
        spread_ref_filter = spread_ref;
        // Alignment is only promised with the crystal reference
        outputs_aligned = !spread_ref;
        selectable_spread = selectable_is_slow ? '0 : {clkgen_regs_pkg::NUM_SELECTABLE{1'b1}};
    end

    ////////////////////////////////////////////////////////////////////////
    // Output enable qualification

    logic [clkgen_regs_pkg::NUM_FAST-1:0] fast_mask;
    logic [clkgen_regs_pkg::NUM_SELECTABLE-1:0] sel_mask;

    assign fast_mask = mask_fast[6:0];
    assign sel_mask = {mask_fast[7], mask_selectable};

    genvar g;
    generate
        for (g = 0; g < clkgen_regs_pkg::NUM_FAST; g++) begin : gen_fast
            assign output_enable.fast[g] = smbus_enable.fast[g] && !enable_pin_n[g]
                && (sideband_latched.fast[g] || fast_mask[g]);
        end
        for (g = 0; g < clkgen_regs_pkg::NUM_SELECTABLE; g++) begin : gen_sel
            assign output_enable.selectable[g] = smbus_enable.selectable[g]
                && (sideband_latched.selectable[g] || sel_mask[g]);
        end
        for (g = 0; g < clkgen_regs_pkg::NUM_SLOW; g++) begin : gen_slow
            assign output_enable.slow[g] = smbus_enable.slow[g]
                && (sideband_latched.slow[g] || mask_slow[g]);
        end
    endgenerate

    assign output_enable.platform_time_output = smbus_enable.platform_time_output
        && (sideband_latched.platform_time_output || mask_slow[3]);

    ////////////////////////////////////////////////////////////////////////
    // Read path: data registered one cycle after the read strobe

    logic [7:0] next_rdata;
    logic next_hit;

    always_comb begin
        next_hit = 1'b1;
        case (bus.addr)
            clkgen_regs_pkg::OFS_DELTA_HIGH: next_rdata = platform_time_delta[15:8];
            clkgen_regs_pkg::OFS_SPREAD: next_rdata = {2'h0, spread_strap_pin,
                spread_ref, spread_pin_disable, spread_select_field};
            clkgen_regs_pkg::OFS_PIN_READBACK: next_rdata = {1'b0, ~enable_pin_n};
            clkgen_regs_pkg::OFS_VENDOR_REV: next_rdata = {clkgen_regs_pkg::DIE_REVISION,
                clkgen_regs_pkg::VENDOR_CODE};
            clkgen_regs_pkg::OFS_DEVICE: next_rdata = {clkgen_regs_pkg::TYPE_CLOCK_GENERATOR,
                clkgen_regs_pkg::DEVICE_IDENTIFIER};
            clkgen_regs_pkg::OFS_BYTE_COUNT: next_rdata = {2'h0, read_count_field};
            clkgen_regs_pkg::OFS_MASK_FAST: next_rdata = mask_fast;
            clkgen_regs_pkg::OFS_MASK_SELECTABLE: next_rdata = mask_selectable;
            clkgen_regs_pkg::OFS_MASK_SLOW: next_rdata = {4'h0, mask_slow};
            default: begin
                next_rdata = 8'h00;
                next_hit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rdata <= 8'h00;
            addr_hit <= 1'b0;
        end else if (bus.rd) begin
            rdata <= next_rdata;
            addr_hit <= next_hit;
        end
    end

endmodule

`default_nettype wire

// file: sim/clkgen_regs_checker.sv
// Assertions on the ports of the clock generator register bank
`timescale 1ns/100ps
`default_nettype none
module clkgen_regs_checker (
    input wire logic ref_clk,
    input wire logic rst,
    input wire clkgen_regs_pkg::reg_access_t bus,
    input wire logic [7:0] rdata,
    input wire logic [15:0] platform_time_delta,
    input wire logic [1:0] spread_strap_pin,
    input wire logic [6:0] enable_pin_n,
    input wire logic spread_ref_filter,
    input wire logic outputs_aligned,
    input wire logic [5:0] read_count_field
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);
    property p_delta;
        bus.rd && bus.addr == 8'h05 |=> rdata == $past(platform_time_delta[15:8]);
    endproperty
    a_delta: assert property (p_delta) else $error("delta byte");
    property p_strap;
        bus.rd && bus.addr == 8'h06 |=> rdata[7:4] == {2'h0, $past(spread_strap_pin)};
    endproperty
    a_strap: assert property (p_strap) else $error("strap readback");
    property p_ref;
        bus.wr && bus.addr == 8'h06 |=> spread_ref_filter == $past(bus.wdata[3]);
    endproperty
    a_ref: assert property (p_ref) else $error("reference select");
    property p_aligned;
        outputs_aligned == !spread_ref_filter;
    endproperty
    a_aligned: assert property (p_aligned) else $error("alignment claim");
    property p_pins;
        bus.rd && bus.addr == 8'h07 |=> rdata == {1'b0, ~$past(enable_pin_n)};
    endproperty
    a_pins: assert property (p_pins) else $error("pin readback");
    property p_ident;
        bus.rd && bus.addr == 8'h08 |=>
            rdata == {clkgen_regs_pkg::DIE_REVISION, clkgen_regs_pkg::VENDOR_CODE};
    endproperty
    a_ident: assert property (p_ident) else $error("ident byte");
    property p_device;
        bus.rd && bus.addr == 8'h09 |=> rdata[7:6] == clkgen_regs_pkg::TYPE_CLOCK_GENERATOR;
    endproperty
    a_device: assert property (p_device) else $error("device type");
    property p_count;
        bus.wr && bus.addr == 8'h0a |=> read_count_field == $past(bus.wdata[5:0]);
    endproperty
    a_count: assert property (p_count) else $error("byte count");
endmodule
bind clock_gen_ctrl_status_regs clkgen_regs_checker chk (.ref_clk, .rst, .bus, .rdata,
    .platform_time_delta, .spread_strap_pin, .enable_pin_n, .spread_ref_filter,
    .outputs_aligned, .read_count_field);
`default_nettype wire

// file: sim/smbus_host_model.sv
// Host side model issuing single byte accesses to the register bank
`timescale 1ns/100ps
`default_nettype none
module smbus_host_model (
    input wire logic ref_clk,
    output var clkgen_regs_pkg::reg_access_t bus
);
    initial bus = '0;
    // One strobe cycle per byte; idle lines show the inverse so stale data is never trusted
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        #1;
        bus = '{w, !w, a, d};
        @(posedge ref_clk);
        #1;
        bus = '{1'b0, 1'b0, ~a, ~d};
    endtask
endmodule
`default_nettype wire

// file: sim/test_clock_gen_ctrl_status_regs.sv
// Self-checking bench of the clock generator register bank
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin mismatches++; \
    $display("mismatch %s exp %h got %h", n, e, g); end end
module test_clock_gen_ctrl_status_regs;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    clkgen_regs_pkg::reg_access_t bus;
    logic [7:0] rdata;
    logic addr_hit;
    logic [15:0] platform_time_delta = 16'hc3a5;
    logic [1:0] spread_strap_pin = 2'h3;
    logic [6:0] enable_pin_n = 7'h35;
    logic selectable_select_pin = 1'b1;
    logic selectable_freq_select = 1'b0;
    logic selectable_freq_control = 1'b0;
    clkgen_regs_pkg::output_vec_t smbus_enable = '1;
    clkgen_regs_pkg::output_vec_t sideband_latched = '0;
    clkgen_regs_pkg::output_vec_t output_enable;
    logic selectable_is_slow;
    logic spread_ref_filter;
    logic outputs_aligned;
    logic [1:0] spread_mode;
    logic [8:0] selectable_spread;
    logic [5:0] read_count_field;
    int mismatches = 0;
    int num_checks = 0;
    int cycles = 0;
    clock_gen_ctrl_status_regs DUT (.ref_clk, .rst, .bus, .rdata, .addr_hit,
        .platform_time_delta, .spread_strap_pin, .enable_pin_n, .selectable_select_pin,
        .selectable_freq_select, .selectable_freq_control, .smbus_enable, .sideband_latched,
        .output_enable, .selectable_is_slow, .spread_mode, .spread_ref_filter,
        .selectable_spread, .outputs_aligned, .read_count_field);
    smbus_host_model host (.ref_clk, .bus);
    initial begin
        forever #2.5 ref_clk = ~ref_clk;
    end
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        host.acc(1'b0, a, 8'h00);
        `CHK("rdata", e, rdata)
    endtask
    task automatic t_spread;
        rd(8'h06, 8'h33);
        spread_strap_pin = 2'h1;
        rd(8'h06, 8'h13);
        `CHK("mode", 2'h1, spread_mode)
        host.acc(1'b1, 8'h06, 8'hff);
        rd(8'h06, 8'h1f);
        `CHK("mode", 2'h3, spread_mode)
        `CHK("aligned", 1'b0, outputs_aligned)
        $display("spread test done");
    endtask
    task automatic t_ident;
        rd(8'h05, 8'hc3);
        `CHK("hit", 1'b1, addr_hit)
        rd(8'h07, 8'h4a);
        rd(8'h08, {clkgen_regs_pkg::DIE_REVISION, clkgen_regs_pkg::VENDOR_CODE});
        host.acc(1'b1, 8'h09, 8'hff);
        rd(8'h09, {2'h0, clkgen_regs_pkg::DEVICE_IDENTIFIER});
        rd(8'h20, 8'h00);
        `CHK("hit", 1'b0, addr_hit)
        rd(8'h0a, 8'h08);
        host.acc(1'b1, 8'h0a, 8'hff);
        rd(8'h0a, 8'h3f);
        $display("ident test done");
    endtask
    task automatic t_mask;
        enable_pin_n = 7'h00;
        #1;
        `CHK("oe", 20'h00000, output_enable)
        host.acc(1'b1, 8'h0b, 8'h80);
        host.acc(1'b1, 8'h0c, 8'h01);
        host.acc(1'b1, 8'h0d, 8'hf8);
        `CHK("oe", 20'h01011, output_enable)
        rd(8'h0d, 8'h08);
        host.acc(1'b1, 8'h0b, 8'h7f);
        `CHK("oe", 20'hfe011, output_enable)
        enable_pin_n = 7'h01;
        #1;
        `CHK("oe", 20'hfc011, output_enable)
        $display("mask test done");
    endtask
    task automatic t_select;
        `CHK("slow", 1'b1, selectable_is_slow)
        `CHK("spread", 9'h000, selectable_spread)
        selectable_freq_control = 1'b1;
        #1;
        `CHK("slow", 1'b0, selectable_is_slow)
        `CHK("spread", 9'h1ff, selectable_spread)
        $display("select test done");
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 2000) begin
            mismatches++;
            test_done();
        end
    end
    initial begin
        repeat (8) @(posedge ref_clk);
        #1;
        rst = 1'b0;
        t_spread();
        t_ident();
        t_mask();
        t_select();
        test_done();
    end
endmodule
`default_nettype wire
